/* File: shared/ep_map_pkg.sv */
// Constants, types and mapping helpers of the alternate address endpoint mapper
package ep_map_pkg;

  localparam int BUS_ADDR_W = 15;
  localparam int BUS_DATA_W = 32;
  localparam int DEV_ADDR_W = 7;
  localparam int EP_W = 4;
  localparam int EP_COUNT = 16;
  localparam int ALT_COUNT = 3;

  // Register indices; the Avalon word address equals the index (byte address is four times it)
  localparam logic [BUS_ADDR_W-1:0] PRIMARY_IDX = 15'h7f92;
  localparam logic [BUS_ADDR_W-1:0] ALT_ONE_IDX = 15'h7f99;
  localparam logic [BUS_ADDR_W-1:0] ALT_TWO_IDX = 15'h7f9e;
  localparam logic [BUS_ADDR_W-1:0] ALT_THREE_IDX = 15'h7f9f;
  localparam logic [BUS_ADDR_W-1:0] LAST_TOKEN_IDX = 15'h7fa0;

  // Alternate filter register layout
  localparam int FILTER_EN_BIT = 7;
  localparam int FILTER_ADDR_MSB = 6;
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [DEV_ADDR_W-1:0] PRIMARY_RESET = 7'h00;

  // Last token status layout: [7] matched, [6:5] filter, [3:0] internal endpoint
  localparam int LAST_MATCH_BIT = 7;
  localparam int LAST_FILTER_LSB = 5;

  typedef enum logic [1:0] {
    filt_primary,
    filt_one,
    filt_two,
    filt_three
  } filter_t;

  // Lowest numbered hitting filter wins; firmware keeps filters disjoint anyway
  function automatic filter_t pick_filter(input logic [3:0] hit);
    filter_t f;
    f = filt_primary;
    if (hit[0]) f = filt_primary;
    else if (hit[1]) f = filt_one;
    else if (hit[2]) f = filt_two;
    else if (hit[3]) f = filt_three;
    return f;
  endfunction : pick_filter

  // Primary keeps the wire endpoint; alternate k gives 4*k plus endpoint modulo 4
  function automatic logic [EP_W-1:0] map_endpoint(input filter_t f, input logic [EP_W-1:0] ep);
    logic [EP_W-1:0] r;
    r = ep;
    if (f != filt_primary) r = {f, ep[1:0]};
    return r;
  endfunction : map_endpoint

endpackage : ep_map_pkg

/* File: core/usb_alt_address_endpoint_mapper.sv */
// Token address filter and external to internal endpoint translation
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Filter two enabled serves internal endpoints 8-11
// - Filter three enabled serves internal endpoints 12-15
// - Disabled filter never affects endpoint match
// - Filter registers: address bits 6:0, enable 7
// - OUT via filter two endpoint 0 heads 8
// - IN via filter two endpoint 0 pops 8
// - Sixteen transmit queues, one per internal endpoint
// - Same translation for IN and OUT traffic
// - Four address filters: primary plus three alternates
// - Several wire endpoints share one internal endpoint
// - Alternate k maps to 4k plus endpoint mod 4
// - Filter one enabled serves internal endpoints 4-7
// - Primary address reaches all endpoints unchanged
module usb_alt_address_endpoint_mapper (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ep_map_pkg::BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ep_map_pkg::BUS_DATA_W-1:0] avs_writedata,
  output logic [ep_map_pkg::BUS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tok_valid,
  input wire logic [ep_map_pkg::DEV_ADDR_W-1:0] tok_addr,
  input wire logic [ep_map_pkg::EP_W-1:0] tok_ep,
  input wire logic tok_is_in,
  output logic endpoint_match_ok,
  output logic [ep_map_pkg::EP_W-1:0] int_ep,
  output logic [ep_map_pkg::DEV_ADDR_W-1:0] hdr_addr,
  output logic hdr_we,
  output logic [ep_map_pkg::EP_COUNT-1:0] tx_pop
);

  logic [ep_map_pkg::DEV_ADDR_W-1:0] primary_local_address_ff;
  logic [7:0] filt_ff [1:ep_map_pkg::ALT_COUNT];
  logic [3:0] hit;
  ep_map_pkg::filter_t nxt_filter;
  logic [ep_map_pkg::EP_W-1:0] nxt_int_ep;
  logic tok_take;

  logic waitrequest_ff;
  logic [ep_map_pkg::BUS_DATA_W-1:0] readdata_ff;
  logic wr_take;
  logic rd_load;

  logic endpoint_match_ok_ff;
  logic [ep_map_pkg::EP_W-1:0] int_ep_ff;
  logic [ep_map_pkg::DEV_ADDR_W-1:0] hdr_addr_ff;
  logic hdr_we_ff;
  logic [ep_map_pkg::EP_COUNT-1:0] tx_pop_ff;
  logic [7:0] last_token_ff;

  // Bus slave: one wait cycle, then the request completes
  assign wr_take = avs_write && !waitrequest_ff;
  assign rd_load = (avs_read || avs_write) && waitrequest_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= !rd_load;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_ff <= 32'h0000_0000;
    end else if (rd_load) begin
      unique case (avs_address)
        ep_map_pkg::PRIMARY_IDX: readdata_ff <= {25'h0, primary_local_address_ff};
        ep_map_pkg::ALT_ONE_IDX: readdata_ff <= {24'h0, filt_ff[1]};
        ep_map_pkg::ALT_TWO_IDX: readdata_ff <= {24'h0, filt_ff[2]};
        ep_map_pkg::ALT_THREE_IDX: readdata_ff <= {24'h0, filt_ff[3]};
        ep_map_pkg::LAST_TOKEN_IDX: readdata_ff <= {24'h0, last_token_ff};
        default: readdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_local_address_ff <= ep_map_pkg::PRIMARY_RESET;
    end else if (wr_take && avs_address == ep_map_pkg::PRIMARY_IDX) begin
      primary_local_address_ff <= avs_writedata[ep_map_pkg::DEV_ADDR_W-1:0];
    end
  end

  // Three alternate filters, each address plus enable
  localparam logic [ep_map_pkg::BUS_ADDR_W-1:0] ALT_IDX [1:3] = '{
    ep_map_pkg::ALT_ONE_IDX, ep_map_pkg::ALT_TWO_IDX, ep_map_pkg::ALT_THREE_IDX};

  genvar k;
  generate
    for (k = 1; k <= ep_map_pkg::ALT_COUNT; k++) begin : g_filt
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          filt_ff[k] <= ep_map_pkg::FILTER_RESET;
        end else if (wr_take && avs_address == ALT_IDX[k]) begin
          filt_ff[k] <= avs_writedata[7:0];
        end
      end
      // Disabled filter contributes nothing to the match
      assign hit[k] = filt_ff[k][ep_map_pkg::FILTER_EN_BIT] &&
                      filt_ff[k][ep_map_pkg::FILTER_ADDR_MSB:0] == tok_addr;
    end
  endgenerate

  assign hit[0] = tok_addr == primary_local_address_ff;
  assign tok_take = tok_valid && (|hit);
  assign nxt_filter = ep_map_pkg::pick_filter(hit);
  assign nxt_int_ep = ep_map_pkg::map_endpoint(nxt_filter, tok_ep);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      endpoint_match_ok_ff <= 1'b0;
    end else begin
      endpoint_match_ok_ff <= tok_take;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_ep_ff <= 4'h0;
      hdr_addr_ff <= 7'h00;
    end else if (tok_take) begin
      int_ep_ff <= nxt_int_ep;
      hdr_addr_ff <= tok_addr;
    end
  end

  // OUT and SETUP tokens write a packet header with the translated endpoint
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_we_ff <= 1'b0;
    end else begin
      hdr_we_ff <= tok_take && !tok_is_in;
    end
  end

  // One dequeue strobe per internal endpoint transmit queue
  genvar e;
  generate
    for (e = 0; e < ep_map_pkg::EP_COUNT; e++) begin : g_pop
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tx_pop_ff[e] <= 1'b0;
        end else begin
          tx_pop_ff[e] <= tok_take && tok_is_in && nxt_int_ep == 4'(e);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_token_ff <= 8'h00;
    end else if (tok_valid) begin
      last_token_ff <= {tok_take, nxt_filter, 1'b0, nxt_int_ep};
    end
  end

  assign avs_waitrequest = waitrequest_ff;
  assign avs_readdata = readdata_ff;
  assign endpoint_match_ok = endpoint_match_ok_ff;
  assign int_ep = int_ep_ff;
  assign hdr_addr = hdr_addr_ff;
  assign hdr_we = hdr_we_ff;
  assign tx_pop = tx_pop_ff;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_alt_two_only;
    tok_valid && hit == 4'b0100;
  endsequence

  sequence s_alt_three_only;
    tok_valid && hit == 4'b1000;
  endsequence

  sequence s_bus_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  alt_two_range_a: assert property (s_alt_two_only |=> int_ep_ff[3:2] == 2'b10)
    else $error("Filter two token left endpoints 8 to 11");

  alt_three_range_a: assert property (s_alt_three_only |=> int_ep_ff[3:2] == 2'b11)
    else $error("Filter three token left endpoints 12 to 15");

  alt_one_range_a: assert property (tok_valid && hit == 4'b0010 |=> int_ep_ff[3:2] == 2'b01)
    else $error("Filter one token left endpoints 4 to 7");

  disabled_filter_a: assert property (
    tok_valid && !hit[0] && !hit[1] && !hit[3] && !filt_ff[2][7]
    |=> !endpoint_match_ok)
    else $error("Disabled filter produced an endpoint match");

  filter_write_a: assert property (
    avs_write && !avs_waitrequest && avs_address == ep_map_pkg::ALT_TWO_IDX
    |=> filt_ff[2] == $past(avs_writedata[7:0]))
    else $error("Filter two register did not take the written value");

  out_header_a: assert property (
    s_alt_two_only ##0 (!tok_is_in && tok_ep == 4'h0)
    |=> hdr_we && int_ep == 4'h8 && hdr_addr == $past(tok_addr))
    else $error("OUT via filter two endpoint 0 not headed as endpoint 8");

  in_pop_a: assert property (
    s_alt_two_only ##0 (tok_is_in && tok_ep == 4'h0) |=> tx_pop == 16'h0100)
    else $error("IN via filter two endpoint 0 did not pop queue 8");

  pop_onehot_a: assert property ($onehot0(tx_pop) && !(hdr_we && |tx_pop))
    else $error("More than one queue or direction strobed at once");

  same_map_a: assert property (
    tok_take |=> ($past(tok_is_in) ? tx_pop == 16'h0001 << int_ep : hdr_we))
    else $error("Queue pop does not follow the translated endpoint");

  four_filters_a: assert property (
    tok_valid && |hit |=> endpoint_match_ok && last_token_ff[7])
    else $error("Hitting filter did not give an endpoint match");

  shared_ep_a: assert property (
    tok_valid && hit == 4'b0010 && tok_ep == 4'hc |=> int_ep == 4'h4)
    else $error("Wire endpoint 12 on filter one not mapped to 4");

  alt_three_map_a: assert property (
    s_alt_three_only ##0 tok_ep == 4'h5 |=> int_ep == 4'hd)
    else $error("Wire endpoint 5 on filter three not mapped to 13");

  primary_keep_a: assert property (
    tok_valid && hit[0] |=> endpoint_match_ok && int_ep == $past(tok_ep))
    else $error("Primary address token changed its endpoint");

  unmatched_a: assert property (
    tok_valid && hit == 4'b0000 |=> !endpoint_match_ok && tx_pop == 16'h0000 && !hdr_we)
    else $error("Unmatched token caused activity");

  bus_answer_a: assert property (s_bus_req_wait |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus request not answered after one wait cycle");

  sequence s_filt_three_read;
    avs_read && avs_waitrequest && avs_address == ep_map_pkg::ALT_THREE_IDX;
  endsequence

  sequence s_idle_token;
    !tok_valid;
  endsequence

  filter_read_a: assert property (
    s_filt_three_read |=> avs_readdata == {24'h0, $past(filt_ff[3])})
    else $error("Filter three register read back a wrong value");

  upper_zero_a: assert property (
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("Register read showed bits above the low byte");

  idle_quiet_a: assert property (
    s_idle_token |=> !endpoint_match_ok && !hdr_we && tx_pop == 16'h0000)
    else $error("Strobe raised without a token");

  hold_endpoint_a: assert property (
    !tok_take |=> $stable(int_ep) && $stable(hdr_addr))
    else $error("Endpoint or header address moved without an accepted token");

  alt_two_pop_a: assert property (
    s_alt_two_only ##0 tok_is_in |=> tx_pop[15:12] == 4'h0 && tx_pop[7:0] == 8'h00)
    else $error("Filter two IN token popped a queue outside 8 to 11");

  alt_three_off_a: assert property (
    tok_valid && !hit[0] && !hit[1] && !hit[2] &&
    !filt_ff[3][ep_map_pkg::FILTER_EN_BIT]
    |=> !endpoint_match_ok)
    else $error("Disabled filter three produced an endpoint match");

  primary_pop_a: assert property (
    tok_valid && hit[0] && tok_is_in |=> tx_pop == 16'h0001 << $past(tok_ep))
    else $error("Primary IN token did not pop its own endpoint queue");

  header_addr_a: assert property (
    tok_take && !tok_is_in |=> hdr_we && hdr_addr == $past(tok_addr))
    else $error("Accepted OUT token wrote no header with its address");

  in_no_header_a: assert property (
    tok_take && tok_is_in |=> !hdr_we && $onehot(tx_pop))
    else $error("Accepted IN token did not pop exactly one queue");

  shared_two_a: assert property (
    s_alt_two_only ##0 tok_ep == 4'h4 |=> int_ep == 4'h8)
    else $error("Wire endpoint 4 on filter two not mapped to 8");

  primary_write_a: assert property (
    avs_write && !avs_waitrequest && avs_address == ep_map_pkg::PRIMARY_IDX
    |=> primary_local_address_ff == $past(avs_writedata[6:0]))
    else $error("Primary address register did not take the written value");

endmodule : usb_alt_address_endpoint_mapper

/* File: testbench/usb_host_model.sv */
// Host side token source for the endpoint mapper bench
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk,
  output logic tok_valid,
  output logic [ep_map_pkg::DEV_ADDR_W-1:0] tok_addr,
  output logic [ep_map_pkg::EP_W-1:0] tok_ep,
  output logic tok_is_in
);
  initial begin
    tok_valid = 1'b0;
    tok_addr = 7'h00;
    tok_ep = 4'h0;
    tok_is_in = 1'b0;
  end
  task automatic send_token(input logic [6:0] a, input logic [3:0] e, input logic in_tok);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_addr <= a;
    tok_ep <= e;
    tok_is_in <= in_tok;
    @(posedge clk);
    // Idle lines show a changed pattern, never the old token
    tok_valid <= 1'b0;
    tok_addr <= ~a;
    tok_ep <= ~e;
    tok_is_in <= ~in_tok;
  endtask : send_token
endmodule : usb_host_model

/* File: testbench/usb_alt_address_endpoint_mapper_tb.sv */
// Self-checking bench of the alternate address endpoint mapper
`timescale 1ns/1ps
module usb_alt_address_endpoint_mapper_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [14:0] avs_address = 15'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tok_valid;
  logic [6:0] tok_addr;
  logic [3:0] tok_ep;
  logic tok_is_in;
  logic endpoint_match_ok;
  logic [3:0] int_ep;
  logic [6:0] hdr_addr;
  logic hdr_we;
  logic [15:0] tx_pop;
  int miscompares = 0;
  int samples_checked = 0;
  logic [6:0] flt_addr [4] = '{7'h00, 7'h00, 7'h00, 7'h00};
  logic flt_en [4] = '{1'b0, 1'b0, 1'b0, 1'b0};
  logic [6:0] pick [5] = '{7'h11, 7'h44, 7'h22, 7'h33, 7'h55};
  logic [14:0] idx [4];
  logic [3:0] last_ep = 4'h0;
  logic [31:0] q;
  logic [7:0] v;

  usb_alt_address_endpoint_mapper u_usb_alt_address_endpoint_mapper (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid), .tok_addr(tok_addr),
    .tok_ep(tok_ep), .tok_is_in(tok_is_in), .endpoint_match_ok(endpoint_match_ok),
    .int_ep(int_ep), .hdr_addr(hdr_addr), .hdr_we(hdr_we), .tx_pop(tx_pop));
  usb_host_model u_usb_host_model (.clk(clk), .tok_valid(tok_valid), .tok_addr(tok_addr),
    .tok_ep(tok_ep), .tok_is_in(tok_is_in));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // Holds the request until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [14:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  function automatic logic [4:0] exp_map(input logic [6:0] a, input logic [3:0] e);
    if (a == flt_addr[0]) return {1'b1, e};
    for (int k = 1; k < 4; k++) begin
      if (flt_en[k] && a == flt_addr[k]) return {1'b1, 2'(k), e[1:0]};
    end
    return 5'h00;
  endfunction : exp_map

  task automatic run_tokens(input int n);
    logic [6:0] a;
    logic [3:0] e;
    logic in_tok;
    logic [4:0] x;
    for (int i = 0; i < n; i++) begin
      a = pick[$urandom_range(4, 0)];
      e = 4'($urandom);
      in_tok = 1'($urandom);
      x = exp_map(a, e);
      u_usb_host_model.send_token(a, e, in_tok);
      // Pulses stand for the cycle after the taking edge
      @(negedge clk);
      check("match", endpoint_match_ok, x[4]);
      check("int_ep", int_ep, x[4] ? x[3:0] : last_ep);
      check("tx_pop", tx_pop, (x[4] && in_tok) ? 16'h1 << x[3:0] : 16'h0);
      check("hdr_we", hdr_we, x[4] & !in_tok);
      if (x[4] && !in_tok) check("hdr_addr", hdr_addr, a);
      if (x[4]) last_ep = x[3:0];
    end
  endtask : run_tokens

  initial begin
    #(50 * 20000);
    miscompares++;
    conclude();
  end

  initial begin
    idx = '{ep_map_pkg::PRIMARY_IDX, ep_map_pkg::ALT_ONE_IDX, ep_map_pkg::ALT_TWO_IDX,
            ep_map_pkg::ALT_THREE_IDX};
    void'($urandom(76));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, idx[k], 32'h0, q);
      check("reset", q, 32'h0);
    end
    bus(1'b0, 15'h7f9d, 32'h0, q);
    check("unmapped", q, 32'h0);
    // Disjoint filters, firmware style
    for (int k = 0; k < 4; k++) begin
      v = {k != 0, pick[k]};
      bus(1'b1, idx[k], {24'($urandom), v}, q);
      bus(1'b0, idx[k], 32'h0, q);
      check("readback", q, k == 0 ? {25'h0, v[6:0]} : {24'h0, v});
      flt_addr[k] = v[6:0];
      flt_en[k] = v[7];
    end
    $display("test registers done");
    run_tokens(300);
    $display("test mapping done");
    bus(1'b1, ep_map_pkg::ALT_THREE_IDX, 32'h33, q);
    flt_en[3] = 1'b0;
    run_tokens(60);
    $display("test disabled filter done");
    u_usb_host_model.send_token(pick[2], 4'h0, 1'b1);
    @(negedge clk);
    check("pop_eight", tx_pop, 32'h0000_0100);
    bus(1'b0, ep_map_pkg::LAST_TOKEN_IDX, 32'h0, q);
    check("last_token", q, 32'h0000_00c8);
    u_usb_host_model.send_token(pick[3], 4'h1, 1'b0);
    bus(1'b0, ep_map_pkg::LAST_TOKEN_IDX, 32'h0, q);
    check("last_unmatched", q[7], 1'b0);
    $display("test status register done");
    conclude();
  end
endmodule : usb_alt_address_endpoint_mapper_tb
